// ### shared/ext_mem_defs.svh
`ifndef EXT_MEM_DEFS_SVH
`define EXT_MEM_DEFS_SVH

// Register byte offsets on the Wishbone slave.
`define SYSCTL2_OFFSET    8'h00
`define WAIT_CFG_OFFSET   8'h04
`define STATUS_OFFSET     8'h08

// Field positions.
`define SYSCTL2_VIS_BIT   0
`define SYSCTL2_BOOT_BIT  2
`define WAIT_PROG_LSB     0
`define WAIT_DATA_LSB     3
`define WAIT_IO_LSB       6
`define WAIT_FIELD_W      3
`define STATUS_BUSY_BIT   0
`define STATUS_EXTEN_BIT  1
`define STATUS_ILL_BIT    2

// Reset values.
`define SYSCTL2_RESET     16'h0000
`define WAIT_CFG_RESET    16'h01FF

// Boot fetch address in either program memory.
`define BOOT_VECTOR       16'h0000

`endif

// ### shared/ext_mem_pkg.sv
package ext_mem_pkg;

  typedef enum logic [1:0] {
    SPACE_PROG,
    SPACE_DATA,
    SPACE_IO
  } space_t;

  typedef enum {
    ST_IDLE,
    ST_ACCESS
  } acc_state_t;

endpackage

// ### shared/ext_cfg_if.sv
`timescale 1ns/1ns
interface ext_cfg_if;
  logic [2:0] wait_prog;
  logic [2:0] wait_data;
  logic [2:0] wait_io;
  logic       vis_mode;
  logic       boot_mp;
  logic       busy;
  logic       ext_en;
  logic       illegal_evt;

  modport regs (
    output wait_prog, wait_data, wait_io, vis_mode,
    input  boot_mp, busy, ext_en, illegal_evt
  );
  modport core (
    input  wait_prog, wait_data, wait_io, vis_mode,
    output boot_mp, busy, ext_en, illegal_evt
  );
endinterface

// ### verilog/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock.
  input  wire logic             clock,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  // No reset, so the pin level is already tracked while reset is held.
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock) begin
    meta <= d;
    q    <= meta;
  end

endmodule

// ### verilog/ext_cfg_regs.sv
`timescale 1ns/1ns
`include "ext_mem_defs.svh"
module ext_cfg_regs (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Configuration to the core and status from it.
  ext_cfg_if.regs          cfg
);

  logic [15:0] system_ctrl_status_reg2;
  logic [15:0] wait_state_config_reg;
  logic        illegal_seen;

  wire         req      = wb_cyc_i & wb_stb_i;
  wire         wr_en    = req & wb_we_i & wb_ack_o;
  wire         hit_scsr = (wb_adr_i == `SYSCTL2_OFFSET);
  wire         hit_wait = (wb_adr_i == `WAIT_CFG_OFFSET);
  wire         hit_stat = (wb_adr_i == `STATUS_OFFSET);
  wire [15:0]  scsr_rd  = {13'h0000, cfg.boot_mp, 1'b0, system_ctrl_status_reg2[0]};
  wire [15:0]  stat_rd  = {13'h0000, illegal_seen, cfg.ext_en, cfg.busy};
  wire [15:0]  rd_mux   = hit_scsr ? scsr_rd :
                          hit_wait ? wait_state_config_reg :
                          hit_stat ? stat_rd : 16'h0000;
  wire         ill_clr  = wr_en & hit_stat & wb_sel_i[0] & wb_dat_i[`STATUS_ILL_BIT];

  assign cfg.vis_mode  = system_ctrl_status_reg2[`SYSCTL2_VIS_BIT];
  assign cfg.wait_prog = wait_state_config_reg[`WAIT_PROG_LSB +: `WAIT_FIELD_W];
  assign cfg.wait_data = wait_state_config_reg[`WAIT_DATA_LSB +: `WAIT_FIELD_W];
  assign cfg.wait_io   = wait_state_config_reg[`WAIT_IO_LSB +: `WAIT_FIELD_W];

  // Ack follows the strobe by one cycle and drops after one; writes land on the ack edge.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      wb_dat_o <= {16'h0000, rd_mux};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      system_ctrl_status_reg2 <= `SYSCTL2_RESET;
      wait_state_config_reg   <= `WAIT_CFG_RESET;
    end else if (wr_en) begin
      if (hit_scsr && wb_sel_i[0]) begin
        system_ctrl_status_reg2[`SYSCTL2_VIS_BIT] <= wb_dat_i[`SYSCTL2_VIS_BIT];
      end
      if (hit_wait && wb_sel_i[0]) begin
        wait_state_config_reg[7:0] <= wb_dat_i[7:0];
      end
      if (hit_wait && wb_sel_i[1]) begin
        wait_state_config_reg[8] <= wb_dat_i[8];
      end
    end
  end

  // A new illegal event in the clearing cycle keeps the flag set.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      illegal_seen <= 1'b0;
    end else begin
      illegal_seen <= cfg.illegal_evt | (illegal_seen & ~ill_clr);
    end
  end

endmodule

// ### verilog/ext_mem_if_wait_boot_ctrl.sv
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/1ns
`include "ext_mem_defs.svh"
module ext_mem_if_wait_boot_ctrl (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // Wishbone register slave.
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Core access request.
  input  wire logic                 req_valid,
  input  wire ext_mem_pkg::space_t  req_space,
  input  wire logic                 req_write,
  input  wire logic [15:0]          req_addr,
  input  wire logic [15:0]          req_wdata,
  output logic                      req_done,
  output logic [15:0]               req_rdata,
  output logic                      illegal_addr,
  // Boot selection.
  input  wire logic                 boot_memory_select,
  output logic                      boot_external,
  output logic [15:0]               boot_vector,
  // Interface enable pin.
  input  wire logic                 ext_interface_enable,
  // External bus pins.
  input  wire logic                 ready,
  output logic [15:0]               ext_addr,
  input  wire logic [15:0]          ext_data_in,
  output logic [15:0]               ext_data_out,
  output logic                      ext_data_oe,
  output logic                      data_space_strobe_n,
  output logic                      io_space_strobe_n,
  output logic                      program_space_strobe_n,
  output logic                      ext_access_strobe_n,
  output logic                      read_strobe_n,
  output logic                      write_strobe_n,
  output logic                      read_write,
  output logic                      visibility_output_enable_n
);
  import ext_mem_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and the register block.

  logic        ready_s;
  logic        bsel_s;
  logic        ext_en_s;
  logic [15:0] din_s;

  pin_sync #(.WIDTH(3)) u_ctl_sync (
    .clock (clock),
    .d     ({ready, boot_memory_select, ext_interface_enable}),
    .q     ({ready_s, bsel_s, ext_en_s})
  );

  // Read data also passes two flops; the device must hold data for the whole access.
  pin_sync #(.WIDTH(16)) u_data_sync (
    .clock (clock),
    .d     (ext_data_in),
    .q     (din_s)
  );

  ext_cfg_if cfg ();

  ext_cfg_regs u_regs (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg      (cfg)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Boot mode capture.

  logic boot_mp;

  // The synchronised pin is loaded all through reset, so the level at release is kept.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      boot_mp <= bsel_s;
    end
  end

  assign cfg.boot_mp   = boot_mp;
  assign boot_external = boot_mp;
  assign boot_vector   = `BOOT_VECTOR;

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer.

  acc_state_t  state;
  space_t      space_q;
  logic        write_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [2:0]  wait_cnt;
  logic [2:0]  wait_cfg_q;

  wire         start      = (state == ST_IDLE) & req_valid & ~req_done;
  wire         go_ext     = start & ext_en_s;
  wire         refuse     = start & ~ext_en_s;
  wire         in_acc     = (state == ST_ACCESS);
  wire [2:0]   wait_sel   = (req_space == SPACE_DATA) ? cfg.wait_data :
                            (req_space == SPACE_IO)   ? cfg.wait_io : cfg.wait_prog;
  wire         wait_left  = (wait_cnt != 3'h0);
  wire         ready_used = (wait_cfg_q != 3'h0);
  wire         finish     = in_acc & ~wait_left & (~ready_used | ready_s);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go_ext) begin
            state <= ST_ACCESS;
          end
        end
        ST_ACCESS: begin
          if (finish) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Software wait states are spent first; ready is only resampled once they are gone.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_cnt   <= 3'h0;
      wait_cfg_q <= 3'h0;
    end else if (go_ext) begin
      wait_cnt   <= wait_sel;
      wait_cfg_q <= wait_sel;
    end else if (in_acc && wait_left) begin
      wait_cnt <= wait_cnt - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      space_q <= SPACE_PROG;
      write_q <= 1'b0;
      addr_q  <= 16'h0000;
      wdata_q <= 16'h0000;
    end else if (go_ext) begin
      space_q <= req_space;
      write_q <= req_write;
      addr_q  <= req_addr;
      wdata_q <= req_wdata;
    end
  end

  // Completion is a registered pulse; refused accesses complete at once with zero data.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_done     <= 1'b0;
      req_rdata    <= 16'h0000;
      illegal_addr <= 1'b0;
    end else begin
      req_done     <= finish | refuse;
      illegal_addr <= refuse & (req_space == SPACE_DATA);
      if (finish && !write_q) begin
        req_rdata <= din_s;
      end else if (refuse) begin
        req_rdata <= 16'h0000;
      end
    end
  end

  assign cfg.busy        = in_acc;
  assign cfg.ext_en      = ext_en_s;
  assign cfg.illegal_evt = illegal_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive.

  assign ext_addr               = addr_q;
  assign ext_data_out           = wdata_q;
  assign ext_data_oe            = in_acc & write_q;
  assign ext_access_strobe_n    = ~in_acc;
  assign data_space_strobe_n    = ~(in_acc & (space_q == SPACE_DATA));
  assign io_space_strobe_n      = ~(in_acc & (space_q == SPACE_IO));
  assign program_space_strobe_n = ~(in_acc & (space_q == SPACE_PROG));
  assign read_strobe_n          = ~(in_acc & ~write_q);
  assign write_strobe_n         = ~(in_acc & write_q);
  assign read_write             = ~(in_acc & write_q);
  // Only the write drive counts, so external decode never sees a false enable.
  assign visibility_output_enable_n = ~(cfg.vis_mode & ext_data_oe);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  logic [3:0] acc_len;

  always_ff @(posedge clock) begin
    if (sys_rst || !in_acc) begin
      acc_len <= 4'h0;
    end else if (acc_len != 4'hF) begin
      acc_len <= acc_len + 4'h1;
    end
  end

  property p_ready_hold;
    @(posedge clock) disable iff (sys_rst)
      (in_acc && !wait_left && ready_used && !ready_s)
        |=> (in_acc && !ext_access_strobe_n);
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("access ended with ready low");

  property p_zero_wait;
    @(posedge clock) disable iff (sys_rst)
      (in_acc && wait_cfg_q == 3'h0) |=> (state == ST_IDLE) && req_done;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("zero-wait access not one cycle");

  property p_wait_first;
    @(posedge clock) disable iff (sys_rst)
      (in_acc && finish) |-> (acc_len >= {1'b0, wait_cfg_q});
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("access shorter than wait count");

  property p_ready_ends;
    @(posedge clock) disable iff (sys_rst)
      (in_acc && !wait_left && ready_s) |=> !in_acc ##0 req_done;
  endproperty
  a_ready_ends: assert property (p_ready_ends) else $error("ready high did not end access");

  property p_boot_bit;
    @(posedge clock)
      ($past(sys_rst) && !sys_rst) |-> (boot_mp == $past(bsel_s)) && (boot_external == boot_mp);
  endproperty
  a_boot_bit: assert property (p_boot_bit) else $error("boot select not captured");

  property p_enable_go;
    @(posedge clock) disable iff (sys_rst)
      (start && ext_en_s) |=> !ext_access_strobe_n;
  endproperty
  a_enable_go: assert property (p_enable_go) else $error("enabled access not started");

  property p_illegal;
    @(posedge clock) disable iff (sys_rst)
      (start && !ext_en_s && req_space == SPACE_DATA)
        |=> illegal_addr && data_space_strobe_n && ext_access_strobe_n;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal data access not flagged");

  property p_vis;
    @(posedge clock) disable iff (sys_rst)
      visibility_output_enable_n == !(cfg.vis_mode && ext_data_oe);
  endproperty
  a_vis: assert property (p_vis) else $error("visibility enable mismatch");

  property p_space;
    @(posedge clock) disable iff (sys_rst)
      (!data_space_strobe_n || !io_space_strobe_n || !program_space_strobe_n)
        |-> !ext_access_strobe_n
            && ($countones({data_space_strobe_n, io_space_strobe_n,
                            program_space_strobe_n}) == 2);
  endproperty
  a_space: assert property (p_space) else $error("space strobes overlap");

  property p_read;
    @(posedge clock) disable iff (sys_rst)
      (in_acc && !write_q) |-> !read_strobe_n && write_strobe_n && !ext_data_oe;
  endproperty
  a_read: assert property (p_read) else $error("read strobe missing");

  property p_write_edge;
    @(posedge clock) disable iff (sys_rst)
      $fell(write_strobe_n) |-> $rose(ext_data_oe);
  endproperty
  a_write_edge: assert property (p_write_edge) else $error("write strobe not with drive");

  property p_strobe;
    @(posedge clock) disable iff (sys_rst)
      $rose(state == ST_ACCESS) |-> !ext_access_strobe_n throughout (in_acc [*1]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("access strobe not low");

endmodule

// ### dv/ext_mem_model.sv
`timescale 1ns/1ns
module ext_mem_model (
  // Clock.
  input  wire logic        clock,
  // Bus from the device.
  input  wire logic        ext_access_strobe_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] ext_data_out,
  // Cycles of ready low per access; zero keeps ready high.
  input  wire logic [3:0]  stall,
  // Answers to the device.
  output logic             ready,
  output logic [15:0]      ext_data_in
);
  logic [15:0] mem [16];
  logic [3:0]  cnt;

  initial begin
    cnt = 4'h0;
    foreach (mem[k]) mem[k] = 16'h0000;
  end

  ////////////////////////////////////////
  // A slow device holds ready low until it has counted its stall cycles.
  assign ready = (stall == 4'h0) || (cnt >= stall);
  // A released bus floats up to its pull-up level.
  assign ext_data_in = read_strobe_n ? 16'hFFFF : mem[ext_addr[3:0]];

  always @(posedge clock) begin
    cnt <= ext_access_strobe_n ? 4'h0 : ((cnt == 4'hF) ? cnt : cnt + 4'h1);
    if (!write_strobe_n) mem[ext_addr[3:0]] <= ext_data_out;
  end
endmodule

// ### dv/tb_ext_mem_if_wait_boot_ctrl.sv
`timescale 1ns/1ns
`include "ext_mem_defs.svh"
`define check_eq(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  $display("unexpected %s expected %h seen %h", nm, e, g); errors++; end end
module tb_ext_mem_if_wait_boot_ctrl;
  import ext_mem_pkg::*;
  typedef struct packed {logic chk; logic ill; logic [15:0] rd;} note_t;
  logic        clock, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, stall;
  logic [31:0] wb_dat_i, wb_dat_o, wq_e;
  logic        req_valid, req_write, req_done, illegal_addr, boot_memory_select;
  logic        boot_external, ext_interface_enable, ready, ext_data_oe, read_write;
  logic        data_space_strobe_n, io_space_strobe_n, program_space_strobe_n;
  logic        ext_access_strobe_n, read_strobe_n, write_strobe_n;
  logic        visibility_output_enable_n, vis_on, dis, cur_write;
  space_t      req_space, cur_space;
  logic [15:0] req_addr, req_wdata, req_rdata, boot_vector, ext_addr, cur_addr;
  logic [15:0] ext_data_in, ext_data_out, a, d;
  logic [15:0] shadow [16];
  logic [2:0]  sp_exp;
  note_t       rq[$];
  note_t       nt_m;
  logic [31:0] wq[$];
  int          errors, n_compared, cycles, seed, lat, i, n;

  ext_mem_if_wait_boot_ctrl dut (
    .clock(clock), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .req_valid(req_valid), .req_space(req_space),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_done(req_done), .req_rdata(req_rdata), .illegal_addr(illegal_addr),
    .boot_memory_select(boot_memory_select), .boot_external(boot_external),
    .boot_vector(boot_vector), .ext_interface_enable(ext_interface_enable),
    .ready(ready), .ext_addr(ext_addr), .ext_data_in(ext_data_in),
    .ext_data_out(ext_data_out), .ext_data_oe(ext_data_oe),
    .data_space_strobe_n(data_space_strobe_n), .io_space_strobe_n(io_space_strobe_n),
    .program_space_strobe_n(program_space_strobe_n),
    .ext_access_strobe_n(ext_access_strobe_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .read_write(read_write),
    .visibility_output_enable_n(visibility_output_enable_n));

  ext_mem_model mem (
    .clock(clock), .ext_access_strobe_n(ext_access_strobe_n),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .ext_addr(ext_addr), .ext_data_out(ext_data_out), .stall(stall),
    .ready(ready), .ext_data_in(ext_data_in));

  ////////////////////////////////////////
  initial clock = 1'b0;
  always #25 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic final_report();
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic wb(input logic w, input logic [7:0] ad, input logic [15:0] dt,
                    input logic [31:0] ex);
    int t;
    t = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= ad;
    wb_dat_i <= {16'h0000, dt};
    if (!w) wq.push_back(ex);
    do begin
      @(posedge clock);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 100);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (t >= 100) errors++;
  endtask

  // Refused accesses return zero; the data bus is only trusted with two or more waits,
  // since the pin synchroniser delays read data by two cycles.
  task automatic access(input space_t sp, input logic w, input logic [15:0] ad, dt,
                        input int ex_lat);
    note_t nt;
    @(posedge clock);
    req_valid <= 1'b1;
    req_space <= sp;
    req_write <= w;
    req_addr  <= ad;
    req_wdata <= dt;
    cur_space = sp;
    cur_write = w;
    cur_addr = ad;
    nt.chk = !w;
    nt.ill = dis && (sp == SPACE_DATA);
    nt.rd = dis ? 16'h0000 : shadow[ad[3:0]];
    rq.push_back(nt);
    if (w && !dis) shadow[ad[3:0]] = dt;
    lat = 0;
    do begin
      @(posedge clock);
      lat++;
    end while (req_done !== 1'b1 && lat < 300);
    req_valid <= 1'b0;
    if (lat >= 300) errors++;
    if (ex_lat > 0) `check_eq("latency", ex_lat, lat)
  endtask

  ////////////////////////////////////////
  assign sp_exp = {cur_space != SPACE_PROG, cur_space != SPACE_DATA, cur_space != SPACE_IO};

  always @(negedge clock) begin
    if (req_done === 1'b1) begin
      nt_m = rq.pop_front();
      `check_eq("illegal_addr", nt_m.ill, illegal_addr)
      if (nt_m.chk) `check_eq("req_rdata", nt_m.rd, req_rdata)
    end
    if (wb_ack_o === 1'b1 && !wb_we_i) begin
      wq_e = wq.pop_front();
      `check_eq("wb_dat_o", wq_e, wb_dat_o)
    end
    if (ext_access_strobe_n === 1'b0) begin
      `check_eq("ext_addr", cur_addr, ext_addr)
      `check_eq("space", sp_exp, {program_space_strobe_n, data_space_strobe_n, io_space_strobe_n})
      `check_eq("dir", {cur_write, !cur_write, cur_write, !cur_write}, {read_strobe_n, write_strobe_n, ext_data_oe, read_write})
    end else
      `check_eq("idle", 7'h7F, {read_strobe_n, write_strobe_n, read_write, !ext_data_oe, program_space_strobe_n, data_space_strobe_n, io_space_strobe_n})
    `check_eq("visibility_output_enable_n", !(vis_on && ext_data_oe), visibility_output_enable_n)
    if (dis) `check_eq("no_strobe", 1'b1, ext_access_strobe_n)
  end

  ////////////////////////////////////////
  initial begin
    seed = 65;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    vis_on = 1'b0;
    dis = 1'b0;
    cur_write = 1'b0;
    cur_space = SPACE_PROG;
    cur_addr = 16'h0000;
    foreach (shadow[k]) shadow[k] = 16'h0000;
    sys_rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, req_valid, req_write} = 5'h00;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    req_space = SPACE_PROG;
    {req_addr, req_wdata} = 32'h0000_0000;
    boot_memory_select = 1'b0;
    ext_interface_enable = 1'b1;
    stall = 4'h0;
    for (i = 0; i < 2; i++) begin
      @(posedge clock);
      sys_rst <= 1'b1;
      boot_memory_select <= i[0];
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      boot_memory_select <= !i[0];
      @(negedge clock);
      `check_eq("boot_external", i[0], boot_external)
      `check_eq("boot_vector", `BOOT_VECTOR, boot_vector)
      wb(1'b0, `SYSCTL2_OFFSET, 16'h0000, {29'h0, i[0], 2'b00});
    end
    wb(1'b0, `WAIT_CFG_OFFSET, 16'h0000, 32'h0000_01FF);
    wb(1'b1, 8'h0C, 16'hFFFF, 32'h0000_0000);
    wb(1'b0, 8'h0C, 16'h0000, 32'h0000_0000);
    for (i = 0; i < 12; i++) begin
      n = 2 + ({$random(seed)} % 6);
      wb(1'b1, `WAIT_CFG_OFFSET, {7'h00, n[2:0], n[2:0], n[2:0]}, 32'h0);
      wb(1'b1, `SYSCTL2_OFFSET, {15'h0000, i[0]}, 32'h0);
      vis_on = i[0];
      a = $random(seed);
      d = $random(seed);
      access(space_t'(i % 3), 1'b1, a, d, n + 3);
      access(space_t'(i % 3), 1'b0, a, 16'h0000, n + 3);
    end
    wb(1'b1, `WAIT_CFG_OFFSET, 16'h0092, 32'h0);
    stall <= 4'h3;
    access(SPACE_DATA, 1'b0, a, 16'h0000, 0);
    `check_eq("stretched", 1'b1, lat > 5 && lat < 12)
    wb(1'b1, `WAIT_CFG_OFFSET, 16'h0000, 32'h0);
    access(SPACE_IO, 1'b1, a, d, 3);
    stall <= 4'h0;
    ext_interface_enable <= 1'b0;
    repeat (4) @(posedge clock);
    dis = 1'b1;
    for (i = 0; i < 3; i++) access(space_t'(i), 1'b0, a, 16'h0000, 2);
    wb(1'b0, `STATUS_OFFSET, 16'h0000, 32'h0000_0004);
    wb(1'b1, `STATUS_OFFSET, 16'h0004, 32'h0);
    ext_interface_enable <= 1'b1;
    dis = 1'b0;
    repeat (4) @(posedge clock);
    wb(1'b0, `STATUS_OFFSET, 16'h0000, 32'h0000_0002);
    access(SPACE_PROG, 1'b1, a, d, 3);
    final_report();
  end
endmodule
